/* File: lfs_map.svh */
// Constants for the LED driver fault supervisor
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH
// ****************************************
// Sizes and encodings
// ****************************************
`define LFS_NCH            6
`define LFS_CLK_HZ         10000000
`define LFS_OPEN_TMO_US    800
// Cycles are the microseconds times the clock in whole MHz, with no round-up
`define LFS_OPEN_TMO_CYC   ((`LFS_OPEN_TMO_US * (`LFS_CLK_HZ / 1000000) + 0) )
`define LFS_PWM_FAULT_CYC  6
`define LFS_SCALE_FULL     2'h0
`define LFS_SCALE_75       2'h1
`define LFS_SCALE_50       2'h2
`define LFS_SCALE_25       2'h3
`define LFS_FSW_600K       1'h0
`define LFS_ST_FAULT_BIT   0
`define LFS_ST_THERM_BIT   1
`define LFS_ST_OVCUR_BIT   2
`define LFS_ST_ON_BIT      3
`define LFS_ST_ONE_BIT     4
`define LFS_ST_TWO_BIT     5
`endif

/* File: lfs_partner.sv */
// Behavioural LED strings and boost stage facing the supervisor
`timescale 1ns/100ps
module lfs_partner
  import lfs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       boost_run,
  input  wire logic [5:0] led_channel_n_on,
  input  wire logic [5:0] open_mask,
  input  wire logic [5:0] short_mask,
  input  wire logic       pwm_run,
  output lfs_chan_type    chan_out,
  output logic            pwm_out
);
  logic [4:0] div_reg = 5'h00;
  // ********************************
  // Dimming period of 20 clocks
  // ********************************
  always @(posedge mclk)
    div_reg <= (div_reg == 5'h13) ? 5'h00 : div_reg + 5'h01;
  // One rising edge per period, low while dimming is stopped
  assign pwm_out = pwm_run & div_reg[4];
  // Strings regulate unless open; a shorted string pulls its pin high
  assign chan_out.at_target    = led_channel_n_on & ~open_mask & {6{boost_run}};
  assign chan_out.below_target = led_channel_n_on & open_mask;
  assign chan_out.above_short  = led_channel_n_on & short_mask;
endmodule : lfs_partner

/* File: lfs_pkg.sv */
// Types for the LED driver fault supervisor
package lfs_pkg;
  typedef enum logic [1:0] {LFS_OFF_S = 2'h0, LFS_RUN_S = 2'h1, LFS_HOT_S = 2'h3, LFS_DEAD_S = 2'h2} lfs_state_type;
  // Per-channel analog comparator indications
  typedef struct packed {
    logic [5:0] at_target;
    logic [5:0] below_target;
    logic [5:0] above_short;
  } lfs_chan_type;
  // Chip-level analog indications
  typedef struct packed {
    logic otp_low;
    logic otp_high;
    logic cooled;
    logic output_overvoltage_limit;
    logic sw_short;
    logic limit_collapse;
    logic in_overcur;
  } lfs_sense_type;
endpackage : lfs_pkg

/* File: lfs_supervisor.sv */
// Fault supervisor logic for the six-channel LED driver
//
// Overview of operation
// (RULE1) While the lower thermal flag is high, every channel below target counts as open.
// (RULE2) A channel open during the lower thermal flag is disabled after 800 us.
// (RULE3) Each upper thermal trip stops boost switching and all current sources.
// (RULE4) Each restart after an upper trip steps DC current to 75, then 50, then 25 percent.
// (RULE5) Thermal cycles never leave the active state; only the enable pin does.
// (RULE6) A shorted channel below the short threshold stays on and others run normally.
// (RULE7) An open channel with infinite resistance is faulted out after 6 PWM cycles.
// (RULE8) A channel above the short threshold is switched off after 6 PWM cycles.
// (RULE9) On output overvoltage, channels below target fault out, regulation returns to others.
// (RULE10) A switch-node short or a sense collapse below 20 percent causes permanent shutdown.
// (RULE11) After power-up the LEDs stay off until the host turns them on over the bus.
// (RULE12) With both bus pins grounded at power-up the LEDs turn on by default.
// (RULE13) Without the bus the boost switching frequency is fixed at 600 kHz.
// (RULE14) A channel is good once at target and becomes open if its current later falls.
// (RULE15) The summary fault flag is the OR of all individual faults.
// (RULE16) The current step saturates at 25 percent and clears only on reset or disable.
`timescale 1ns/100ps
`include "lfs_map.svh"
module lfs_supervisor
  import lfs_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          enable_pin,
  input  wire logic          sda_in,
  input  wire logic          scl_in,
  input  wire logic          host_bl_on,
  input  wire logic          host_fsw_sel,
  input  wire logic          pwm_cycle_end,
  input  wire lfs_chan_type  chan_in,
  input  wire lfs_sense_type sense_in,
  output logic               boost_run,
  output logic [5:0]         led_channel_n_on,
  output logic [1:0]         dc_scale,
  output logic               fsw_sel,
  output logic               bus_unused,
  output logic [5:0]         chan_fault,
  output logic [7:0]         status
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NI = 4 + 18 + 7;
  logic [NI-1:0] sync1_reg;
  logic [NI-1:0] sync2_reg;
  logic [NI-1:0] raw_in;
  assign raw_in = {enable_pin, sda_in, scl_in, pwm_cycle_end, chan_in, sense_in};

  // Two-flop synchroniser for all pin-level inputs
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic          en_s;
  logic          sda_s;
  logic          scl_s;
  logic          pwm_s;
  lfs_chan_type  ch_s;
  lfs_sense_type se_s;
  assign {en_s, sda_s, scl_s, pwm_s, ch_s, se_s} = sync2_reg;

  // ****************************************
  // Timing constants
  // ****************************************
  localparam logic [12:0] OPEN_TMO = 13'(`LFS_OPEN_TMO_CYC);
  localparam logic [2:0]  PWM_TMO  = 3'(`LFS_PWM_FAULT_CYC);

  // Saturating step of the current reduction
  function automatic logic [1:0] lfs_step(input logic [1:0] s);
    lfs_step = (s == `LFS_SCALE_25) ? `LFS_SCALE_25 : 2'(s + 2'h1);
  endfunction : lfs_step

  // ****************************************
  // State and registers
  // ****************************************
  lfs_state_type state_reg, state_next;
  logic [1:0]    scale_reg, scale_next;
  logic          strap_reg, strap_next;
  logic [1:0]    seen_reg, seen_next;
  logic          pwm_d_reg, pwm_d_next;
  logic          ovc_reg, ovc_next;
  logic [5:0]    good_reg, good_next;
  logic [5:0]    flt_reg, flt_next;
  logic [12:0]   otmo_reg [6];
  logic [12:0]   otmo_next [6];
  logic [2:0]    pcnt_reg [6];
  logic [2:0]    pcnt_next [6];
  logic          pwm_edge;
  logic [5:0]    open_now;
  logic [5:0]    hot_open;
  logic [2:0]    nflt;

  assign pwm_edge = pwm_s & ~pwm_d_reg;

  // Next-state computation
  always_comb
  begin
    state_next = state_reg;
    scale_next = scale_reg;
    strap_next = strap_reg;
    seen_next  = (seen_reg == 2'h3) ? 2'h3 : 2'(seen_reg + 2'h1);
    pwm_d_next = pwm_s;
    ovc_next   = ovc_reg | se_s.in_overcur;
    good_next  = good_reg;
    flt_next   = flt_reg;
    open_now   = '0;
    hot_open   = '0;
    for (int i = 0; i < 6; i++)
    begin
      otmo_next[i] = (state_reg == LFS_OFF_S) ? 13'h0 : otmo_reg[i]; // No count survives a disable
      pcnt_next[i] = (state_reg == LFS_OFF_S) ? 3'h0 : pcnt_reg[i];
    end
    // Strap caught once the pins have passed both flops
    if (seen_reg != 2'h3)
      strap_next = ~sda_s & ~scl_s; // RULE12
    case (state_reg)
      LFS_OFF_S:
      begin
        scale_next = `LFS_SCALE_FULL; // RULE16
        good_next  = '0;
        flt_next   = '0;
        ovc_next   = 1'h0;
        if (en_s && seen_reg == 2'h3)
          state_next = LFS_RUN_S;
      end
      LFS_RUN_S:
      begin
        if (se_s.sw_short || se_s.limit_collapse)
          state_next = LFS_DEAD_S; // RULE10
        else if (se_s.otp_high)
          state_next = LFS_HOT_S; // RULE3
        for (int i = 0; i < 6; i++)
        begin
          if (ch_s.at_target[i])
            good_next[i] = 1'h1; // RULE14
          open_now[i] = ch_s.below_target[i]
                        & (good_reg[i] | se_s.output_overvoltage_limit | se_s.otp_low); // RULE1 RULE9 RULE14
          hot_open[i] = ch_s.below_target[i] & se_s.otp_low;
          // Fast timeout while hot
          if (hot_open[i] && !flt_reg[i])
          begin
            if (otmo_reg[i] >= OPEN_TMO - 13'h1)
              flt_next[i] = 1'h1; // RULE2
            else
              otmo_next[i] = otmo_reg[i] + 13'h1;
          end
          else
            otmo_next[i] = '0;
          // PWM-cycle timeout for open or over-voltage channels
          if ((open_now[i] || ch_s.above_short[i] || (ch_s.below_target[i] && !good_reg[i])) && !flt_reg[i])
          begin
            if (pwm_edge)
            begin
              if (pcnt_reg[i] >= PWM_TMO - 3'h1)
                flt_next[i] = 1'h1; // RULE7 RULE8 RULE9
              else
                pcnt_next[i] = pcnt_reg[i] + 3'h1;
            end
          end
          else
            pcnt_next[i] = '0; // RULE6
        end
      end
      LFS_HOT_S:
      begin
        if (se_s.cooled && !se_s.otp_high)
        begin
          state_next = LFS_RUN_S;
          scale_next = lfs_step(scale_reg); // RULE4 RULE16
        end
      end
      default:
        state_next = LFS_DEAD_S;
    endcase
    // Only the enable pin leaves the active states
    if (!en_s)
      state_next = LFS_OFF_S; // RULE5
  end

  // Register update
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= LFS_OFF_S;
      scale_reg <= `LFS_SCALE_FULL;
      strap_reg <= 1'h0;
      seen_reg  <= 2'h0;
      pwm_d_reg <= 1'h0;
      ovc_reg   <= 1'h0;
      good_reg  <= '0;
      flt_reg   <= '0;
      for (int i = 0; i < 6; i++)
      begin
        otmo_reg[i] <= '0;
        pcnt_reg[i] <= '0;
      end
    end
    else
    begin
      state_reg <= state_next;
      scale_reg <= scale_next;
      strap_reg <= strap_next;
      seen_reg  <= seen_next;
      pwm_d_reg <= pwm_d_next;
      ovc_reg   <= ovc_next;
      good_reg  <= good_next;
      flt_reg   <= flt_next;
      for (int i = 0; i < 6; i++)
      begin
        otmo_reg[i] <= otmo_next[i];
        pcnt_reg[i] <= pcnt_next[i];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic lit;
  assign lit = (state_reg == LFS_RUN_S) & (strap_reg | host_bl_on); // RULE11 RULE12

  // Count of shut channels
  always_comb
  begin
    nflt = '0;
    for (int i = 0; i < 6; i++)
      nflt = nflt + {2'h0, flt_reg[i]};
  end

  // Output registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      boost_run        <= 1'h0;
      led_channel_n_on <= '0;
      dc_scale         <= `LFS_SCALE_FULL;
      fsw_sel          <= `LFS_FSW_600K;
      bus_unused       <= 1'h0;
      chan_fault       <= '0;
      status           <= '0;
    end
    else
    begin
      boost_run        <= lit; // RULE3
      led_channel_n_on <= lit ? ~flt_reg : 6'h00; // RULE3 RULE6
      dc_scale         <= scale_reg;
      fsw_sel          <= strap_reg ? `LFS_FSW_600K : host_fsw_sel; // RULE13
      bus_unused       <= strap_reg;
      chan_fault       <= flt_reg;
      status           <= 8'h00;
      status[`LFS_ST_THERM_BIT] <= (state_reg == LFS_HOT_S);
      status[`LFS_ST_OVCUR_BIT] <= ovc_reg;
      status[`LFS_ST_ON_BIT]    <= lit;
      status[`LFS_ST_ONE_BIT]   <= (nflt == 3'h1);
      status[`LFS_ST_TWO_BIT]   <= (nflt >= 3'h2);
      status[`LFS_ST_FAULT_BIT] <= (|flt_reg) | ovc_reg | (state_reg == LFS_HOT_S)
                                   | (state_reg == LFS_DEAD_S); // RULE15
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_hot_dark;
    @(posedge mclk) disable iff (!rstn) (state_reg == LFS_HOT_S) |=> !boost_run && led_channel_n_on == 6'h00;
  endproperty
  a_hot_dark: assert property (p_hot_dark) else $error("outputs on during thermal trip"); // RULE3

  property p_step;
    @(posedge mclk) disable iff (!rstn)
      (state_reg == LFS_HOT_S && state_next == LFS_RUN_S && scale_reg != `LFS_SCALE_25)
      |=> scale_reg == $past(scale_reg) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("current step wrong"); // RULE4

  property p_sat;
    @(posedge mclk) disable iff (!rstn) (scale_reg == `LFS_SCALE_25 && en_s) |=> scale_reg == `LFS_SCALE_25;
  endproperty
  a_sat: assert property (p_sat) else $error("step left saturation"); // RULE16

  property p_active;
    @(posedge mclk) disable iff (!rstn) (state_reg != LFS_OFF_S && en_s) |=> state_reg != LFS_OFF_S;
  endproperty
  a_active: assert property (p_active) else $error("left active state"); // RULE5

  property p_dead;
    @(posedge mclk) disable iff (!rstn) (state_reg == LFS_DEAD_S && en_s) |=> state_reg == LFS_DEAD_S;
  endproperty
  a_dead: assert property (p_dead) else $error("shutdown not permanent"); // RULE10

  property p_short_fast;
    @(posedge mclk) disable iff (!rstn)
      (state_reg == LFS_RUN_S && en_s && (se_s.sw_short || se_s.limit_collapse)) |=> state_reg == LFS_DEAD_S;
  endproperty
  a_short_fast: assert property (p_short_fast) else $error("short not caught"); // RULE10

  property p_fault_or;
    @(posedge mclk) disable iff (!rstn) (|chan_fault) |-> status[`LFS_ST_FAULT_BIT];
  endproperty
  a_fault_or: assert property (p_fault_or) else $error("summary flag missing"); // RULE15

  property p_fsw;
    @(posedge mclk) disable iff (!rstn) bus_unused |-> fsw_sel == `LFS_FSW_600K;
  endproperty
  a_fsw: assert property (p_fsw) else $error("frequency not fixed"); // RULE13

  property p_off_default;
    @(posedge mclk) disable iff (!rstn) (!strap_reg && !host_bl_on) |=> led_channel_n_on == 6'h00;
  endproperty
  a_off_default: assert property (p_off_default) else $error("LEDs on without host"); // RULE11

  property p_tmo;
    @(posedge mclk) disable iff (!rstn) (otmo_reg[0] == OPEN_TMO - 13'h1 && hot_open[0] && state_reg == LFS_RUN_S && en_s)
      |=> flt_reg[0];
  endproperty
  a_tmo: assert property (p_tmo) else $error("hot timeout missed"); // RULE2

endmodule : lfs_supervisor

/* File: tb_top.sv */
// Self-checking bench for the LED driver fault supervisor
`timescale 1ns/100ps
module tb_top
  import lfs_pkg::*;
;
  logic          mclk, rstn, enable_pin, sda_in, scl_in, host_bl_on, host_fsw_sel, pwm_run;
  logic [5:0]    open_mask, short_mask, led_channel_n_on, chan_fault;
  logic          pwm_cycle_end, boost_run, fsw_sel, bus_unused;
  logic [1:0]    dc_scale;
  logic [7:0]    status;
  lfs_chan_type  chan_in;
  lfs_sense_type sense_in;
  int            num_errors, checks;
  int            cyc = 0;

  lfs_supervisor u_lfs_supervisor (.mclk(mclk), .rstn(rstn), .enable_pin(enable_pin), .sda_in(sda_in),
    .scl_in(scl_in), .host_bl_on(host_bl_on), .host_fsw_sel(host_fsw_sel), .pwm_cycle_end(pwm_cycle_end),
    .chan_in(chan_in), .sense_in(sense_in), .boost_run(boost_run), .led_channel_n_on(led_channel_n_on),
    .dc_scale(dc_scale), .fsw_sel(fsw_sel), .bus_unused(bus_unused), .chan_fault(chan_fault), .status(status));
  lfs_partner u_lfs_partner (.mclk(mclk), .boost_run(boost_run), .led_channel_n_on(led_channel_n_on),
    .open_mask(open_mask), .short_mask(short_mask), .pwm_run(pwm_run), .chan_out(chan_in), .pwm_out(pwm_cycle_end));

  // ********************************
  // Clock, hang guard and helpers
  // ********************************
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Cut a hang short
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks = checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Wait edges, then step just past the last one
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask : wt
  task automatic power_up(input logic strap);
    rstn = 1'b0;
    sda_in = strap;
    scl_in = strap;
    wt(10);
    chk("boost_run", 8'h00, boost_run);
    chk("led_on", 8'h00, led_channel_n_on);
    chk("status", 8'h00, status);
    rstn = 1'b1;
    wt(12);
  endtask : power_up
  // Disable and enable again with a healthy load
  task automatic restart;
    open_mask = 6'h00;
    short_mask = 6'h00;
    pwm_run = 1'b0;
    sense_in = '0;
    enable_pin = 1'b0;
    wt(8);
    enable_pin = 1'b1;
    wt(8);
  endtask : restart
  task automatic end_of_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_strap;
    power_up(1'b0);
    chk("bus_unused", 8'h01, bus_unused);
    chk("led_on", 8'h3f, led_channel_n_on);
    chk("fsw_sel", 8'h00, fsw_sel);
  endtask : t_strap
  task automatic t_host;
    power_up(1'b1);
    chk("led_on", 8'h00, led_channel_n_on);
    chk("bus_unused", 8'h00, bus_unused);
    chk("fsw_sel", 8'h01, fsw_sel);
    host_bl_on = 1'b1;
    wt(8);
    chk("led_on", 8'h3f, led_channel_n_on);
  endtask : t_host
  task automatic t_pwm;
    restart();
    open_mask = 6'h04;
    pwm_run = 1'b1;
    wt(90);
    chk("chan_fault", 8'h00, chan_fault);
    wt(70);
    chk("chan_fault", 8'h04, chan_fault);
    chk("led_on", 8'h3b, led_channel_n_on);
    chk("status", 8'h19, status);
    short_mask = 6'h10;
    wt(160);
    chk("chan_fault", 8'h14, chan_fault);
    chk("two_shut", 8'h01, status[5]);
  endtask : t_pwm
  // Channel open from the start, once plain and once with the output over its limit
  task automatic t_never;
    int k;
    for (k = 0; k < 2; k++)
    begin
      restart();
      enable_pin = 1'b0;
      open_mask = 6'h02;
      sense_in.output_overvoltage_limit = (k == 1);
      sense_in.in_overcur = (k == 1);
      wt(8);
      enable_pin = 1'b1;
      pwm_run = 1'b1;
      wt(100);
      chk("chan_fault", 8'h00, chan_fault);
      wt(30);
      chk("chan_fault", 8'h02, chan_fault);
      chk("led_on", 8'h3d, led_channel_n_on);
      chk("status", (k == 1) ? 8'h1d : 8'h19, status);
    end
  endtask : t_never
  task automatic t_otp_low;
    restart();
    open_mask = 6'h01;
    sense_in.otp_low = 1'b1;
    wt(7900);
    chk("chan_fault", 8'h00, chan_fault);
    wt(200);
    chk("chan_fault", 8'h01, chan_fault);
  endtask : t_otp_low
  task automatic t_therm;
    int i;
    restart();
    for (i = 1; i < 5; i++)
    begin
      sense_in.otp_high = 1'b1;
      wt(8);
      chk("boost_run", 8'h00, boost_run);
      chk("led_on", 8'h00, led_channel_n_on);
      chk("thermal", 8'h03, status[1:0]);
      sense_in.otp_high = 1'b0;
      sense_in.cooled = 1'b1;
      wt(8);
      sense_in.cooled = 1'b0;
      wt(8);
      chk("dc_scale", (i > 3) ? 8'h03 : 8'(i), dc_scale);
      chk("boost_run", 8'h01, boost_run);
    end
    restart();
    chk("dc_scale", 8'h00, dc_scale);
  endtask : t_therm
  task automatic t_dead;
    int k;
    for (k = 0; k < 2; k++)
    begin
      restart();
      sense_in.sw_short = (k == 0);
      sense_in.limit_collapse = (k == 1);
      wt(8);
      sense_in = '0;
      wt(8);
      chk("boost_run", 8'h00, boost_run);
      chk("led_on", 8'h00, led_channel_n_on);
    end
  endtask : t_dead

  // Main sequence
  initial
  begin
    num_errors = 0;
    checks = 0;
    rstn = 1'b0;
    enable_pin = 1'b1;
    host_bl_on = 1'b0;
    host_fsw_sel = 1'b1;
    pwm_run = 1'b0;
    open_mask = 6'h00;
    short_mask = 6'h00;
    sense_in = '0;
    sda_in = 1'b0;
    scl_in = 1'b0;
    t_strap();
    t_host();
    t_pwm();
    t_never();
    t_otp_low();
    t_therm();
    t_dead();
    end_of_test();
  end
endmodule : tb_top
